// file: rtl/gp_dev.sv
// device end: function control for two multifunction pins
// assumes link strobes on CLOCK, pins asynchronous to CLOCK
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "gp_defines.svh"
module gp_dev
    import gp_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RST,
    gp_link_if.dev LINK,
    input wire logic MULTI_PIN_ONE_I,
    output logic MULTI_PIN_ONE_O,
    output logic MULTI_PIN_ONE_OE_N,
    input wire logic MULTI_PIN_TWO_I,
    output logic MULTI_PIN_TWO_O,
    output logic MULTI_PIN_TWO_OE_N,
    input wire logic FAULT_EVENT,
    output logic RF_SYNC_INPUT_ONE,
    output logic RF_SYNC_INPUT_TWO,
    output logic IRQ
);
    typedef struct packed
    {
        logic [7:0] ctl;
        logic arm1;
        logic arm2;
        logic pend1;
        logic pend2;
        logic [2:0] sy1;
        logic [2:0] sy2;
        logic lvl1;
        logic lvl2;
        logic [`GP_EV_W-1:0] sts;
        logic [`GP_EV_W-1:0] msk;
        logic [7:0] rdata;
        logic irq;
        logic p1_o;
        logic p1_oe_n;
        logic p2_o;
        logic p2_oe_n;
        logic sync1;
        logic sync2;
    } gp_dev_st_t;

    gp_dev_st_t st_ff;
    gp_dev_st_t nxt_st;

    logic wr_ctl;
    logic out1_req;
    logic out2_req;
    logic in1_gpio;
    logic in2_gpio;
    logic int_mode;
    logic [`GP_EV_W-1:0] ev;
    logic [7:0] new_ctl;

    always_comb
    begin
        nxt_st = st_ff;
        wr_ctl = LINK.wr && (LINK.addr == `GP_ADDR_CTL);
        out1_req = LINK.wdata[`GP_B_P1_SEL] && LINK.wdata[`GP_B_P1_DIR];
        out2_req = LINK.wdata[`GP_B_P2_SEL] && LINK.wdata[`GP_B_P2_DIR];
        in1_gpio = LINK.wdata[`GP_B_P1_SEL] && !LINK.wdata[`GP_B_P1_DIR];
        in2_gpio = LINK.wdata[`GP_B_P2_SEL] && !LINK.wdata[`GP_B_P2_DIR];
        ev = '0;
        new_ctl = LINK.wdata;

        // three-stage synchronisers; level accepted once stages two and three agree
        nxt_st.sy1 = {st_ff.sy1[1:0], MULTI_PIN_ONE_I};
        nxt_st.sy2 = {st_ff.sy2[1:0], MULTI_PIN_TWO_I};
        if (st_ff.sy1[1] == st_ff.sy1[2])
        begin
            nxt_st.lvl1 = st_ff.sy1[2];
        end
        if (st_ff.sy2[1] == st_ff.sy2[2])
        begin
            nxt_st.lvl2 = st_ff.sy2[2];
        end

        // input change events only while the pin is a gpio input
        ev[`GP_B_EV_P1] = (nxt_st.lvl1 != st_ff.lvl1)
            && st_ff.ctl[`GP_B_P1_SEL] && !st_ff.ctl[`GP_B_P1_DIR];
        ev[`GP_B_EV_P2] = (nxt_st.lvl2 != st_ff.lvl2)
            && st_ff.ctl[`GP_B_P2_SEL] && !st_ff.ctl[`GP_B_P2_DIR];
        ev[`GP_B_EV_FLT] = FAULT_EVENT;

        if (wr_ctl)
        begin
            // input bits take the pin level at the write, not live later
            if (in1_gpio)
            begin
                new_ctl[`GP_B_P1_DAT] = st_ff.lvl1;
            end
            if (in2_gpio)
            begin
                new_ctl[`GP_B_P2_DAT] = st_ff.lvl2;
            end
            new_ctl[`GP_B_UNUSED] = 1'b0;
            nxt_st.ctl = new_ctl;

            // output drive is armed only by two writes in succession
            if (!out1_req)
            begin
                nxt_st.arm1 = 1'b0;
                nxt_st.pend1 = 1'b0;
            end
            else if (!st_ff.arm1)
            begin
                nxt_st.arm1 = st_ff.pend1;
                nxt_st.pend1 = !st_ff.pend1;
            end
            if (!out2_req)
            begin
                nxt_st.arm2 = 1'b0;
                nxt_st.pend2 = 1'b0;
            end
            else if (!st_ff.arm2)
            begin
                nxt_st.arm2 = st_ff.pend2;
                nxt_st.pend2 = !st_ff.pend2;
            end
        end
        else if (LINK.wr)
        begin
            // any other write breaks a half-finished set-up pair
            nxt_st.pend1 = 1'b0;
            nxt_st.pend2 = 1'b0;
            if (LINK.addr == `GP_ADDR_STS)
            begin
                nxt_st.sts = st_ff.sts & ~LINK.wdata[`GP_EV_W-1:0];
            end
            if (LINK.addr == `GP_ADDR_MSK)
            begin
                nxt_st.msk = LINK.wdata[`GP_EV_W-1:0];
            end
        end
        // a new event wins over a clear in the same cycle
        nxt_st.sts = nxt_st.sts | ev;
        nxt_st.irq = |(nxt_st.sts & nxt_st.msk);

        // read data stands the cycle after the strobe only
        nxt_st.rdata = 8'h00;
        if (LINK.rd)
        begin
            unique case (LINK.addr)
                `GP_ADDR_CTL: nxt_st.rdata = {1'b0, st_ff.ctl[6:0]};
                `GP_ADDR_STS: nxt_st.rdata = {5'h00, st_ff.sts};
                `GP_ADDR_MSK: nxt_st.rdata = {5'h00, st_ff.msk};
                default: nxt_st.rdata = 8'h00;
            endcase
        end

        // pin one: sync input or gpio; drive only once armed
        nxt_st.p1_o = nxt_st.ctl[`GP_B_P1_DAT];
        nxt_st.p1_oe_n = !(nxt_st.ctl[`GP_B_P1_SEL] && nxt_st.ctl[`GP_B_P1_DIR]
            && nxt_st.arm1);
        nxt_st.sync1 = nxt_st.ctl[`GP_B_P1_SEL] ? 1'b0 : nxt_st.lvl1;

        // pin two: interrupt mode needs bit6 and bits 4:3 both set
        int_mode = nxt_st.ctl[`GP_B_INT_EN] && nxt_st.ctl[`GP_B_P2_DIR]
            && nxt_st.ctl[`GP_B_P2_SEL] && nxt_st.arm2;
        if (int_mode)
        begin
            // open-drain active low: pulled low only while interrupt pends
            nxt_st.p2_o = 1'b0;
            nxt_st.p2_oe_n = !nxt_st.irq;
        end
        else
        begin
            nxt_st.p2_o = nxt_st.ctl[`GP_B_P2_DAT];
            nxt_st.p2_oe_n = !(nxt_st.ctl[`GP_B_P2_SEL]
                && nxt_st.ctl[`GP_B_P2_DIR] && nxt_st.arm2);
        end
        // with bit6 clear or bits 4:3 not both set, bit 3 decides
        nxt_st.sync2 = nxt_st.ctl[`GP_B_P2_SEL] ? 1'b0 : nxt_st.lvl2;

        if (RST)
        begin
            nxt_st = '0;
            nxt_st.ctl = `GP_CTL_RESET;
            nxt_st.p1_oe_n = 1'b1;
            nxt_st.p2_oe_n = 1'b1;
        end
    end

    always_ff @(posedge CLOCK)
    begin
        st_ff <= nxt_st;
    end

    assign LINK.rdata = st_ff.rdata;
    assign MULTI_PIN_ONE_O = st_ff.p1_o;
    assign MULTI_PIN_ONE_OE_N = st_ff.p1_oe_n;
    assign MULTI_PIN_TWO_O = st_ff.p2_o;
    assign MULTI_PIN_TWO_OE_N = st_ff.p2_oe_n;
    assign RF_SYNC_INPUT_ONE = st_ff.sync1;
    assign RF_SYNC_INPUT_TWO = st_ff.sync2;
    assign IRQ = st_ff.irq;
endmodule
`default_nettype wire

// file: pkg/gp_defines.svh
// constants for the two-pin function control block and its host end
// assumes inclusion by bare name from package and design files
`ifndef GP_DEFINES_SVH
`define GP_DEFINES_SVH
// device register map
`define GP_ADDR_CTL 8'h20
`define GP_ADDR_STS 8'h21
`define GP_ADDR_MSK 8'h22
`define GP_CTL_RESET 8'h00
// control register fields
`define GP_B_P1_SEL 0
`define GP_B_P1_DIR 1
`define GP_B_P1_DAT 2
`define GP_B_P2_SEL 3
`define GP_B_P2_DIR 4
`define GP_B_P2_DAT 5
`define GP_B_INT_EN 6
`define GP_B_UNUSED 7
// status and mask fields
`define GP_B_EV_P1 0
`define GP_B_EV_P2 1
`define GP_B_EV_FLT 2
`define GP_EV_W 3
// host command port map
`define GP_H_ADDR 8'h00
`define GP_H_DATA 8'h01
`define GP_H_CMD 8'h02
`define GP_H_STAT 8'h03
`define GP_H_RDAT 8'h04
`define GP_C_WRITE 0
`define GP_C_READ 1
`define GP_C_REFRESH 2
`endif

// file: pkg/gp_pkg.sv
// types shared by the device end and the host end
// assumes gp_defines.svh on the include path
`include "gp_defines.svh"
package gp_pkg;
    typedef enum logic [2:0]
    {
        GP_H_IDLE = 3'b000,
        GP_H_WR1 = 3'b001,
        GP_H_WR2 = 3'b010,
        GP_H_RD = 3'b011,
        GP_H_CAP = 3'b100
    } gp_hstate_t;
endpackage

// file: pkg/gp_link_if.sv
// register link between host end and device end
// assumes both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none
interface gp_link_if;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] rdata;
    modport host
    (
        output addr,
        output wdata,
        output wr,
        output rd,
        input rdata
    );
    modport dev
    (
        input addr,
        input wdata,
        input wr,
        input rd,
        output rdata
    );
endinterface
`default_nettype wire

// file: rtl/gp_host.sv
// host end: drives the register link with the needed write sequences
// assumes software port on CLOCK, device answers reads one cycle later
`timescale 1ns/1ps
`default_nettype none
`include "gp_defines.svh"
module gp_host
    import gp_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RST,
    gp_link_if.host LINK,
    input wire logic [7:0] SW_ADDR,
    input wire logic [7:0] SW_WDATA,
    input wire logic SW_WR,
    input wire logic SW_RD,
    output logic [7:0] SW_RDATA
);
    typedef struct packed
    {
        gp_hstate_t state;
        logic [7:0] addr;
        logic [7:0] data;
        logic [7:0] rdat;
        logic [7:0] shadow;
        logic done1;
        logic done2;
        logic dbl;
        logic then_rd;
        logic [7:0] l_addr;
        logic [7:0] l_wdata;
        logic l_wr;
        logic l_rd;
        logic [7:0] sw_rdata;
    } gp_host_st_t;

    gp_host_st_t st_ff;
    gp_host_st_t nxt_st;
    logic busy;
    logic go_wr;

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.l_wr = 1'b0;
        nxt_st.l_rd = 1'b0;
        nxt_st.sw_rdata = 8'h00;
        busy = (st_ff.state != GP_H_IDLE);
        go_wr = 1'b0;

        if (SW_WR)
        begin
            unique case (SW_ADDR)
                `GP_H_ADDR: nxt_st.addr = SW_WDATA;
                `GP_H_DATA: nxt_st.data = SW_WDATA;
                `GP_H_CMD:
                begin
                    // commands while busy are dropped; poll the busy bit
                    if (!busy && SW_WDATA[`GP_C_WRITE])
                    begin
                        go_wr = 1'b1;
                        nxt_st.then_rd = 1'b0;
                    end
                    else if (!busy && SW_WDATA[`GP_C_READ])
                    begin
                        nxt_st.state = GP_H_RD;
                    end
                    else if (!busy && SW_WDATA[`GP_C_REFRESH])
                    begin
                        // rewrite the control value, then read back
                        nxt_st.addr = `GP_ADDR_CTL;
                        nxt_st.data = st_ff.shadow;
                        go_wr = 1'b1;
                        nxt_st.then_rd = 1'b1;
                    end
                end
                default: nxt_st.addr = st_ff.addr;
            endcase
        end
        if (go_wr)
        begin
            // first output set-up of a pin needs the write twice
            nxt_st.dbl = (nxt_st.addr == `GP_ADDR_CTL) && (
                (nxt_st.data[`GP_B_P1_SEL] && nxt_st.data[`GP_B_P1_DIR] && !st_ff.done1)
                || (nxt_st.data[`GP_B_P2_SEL] && nxt_st.data[`GP_B_P2_DIR]
                && !st_ff.done2));
            nxt_st.state = GP_H_WR1;
        end

        if (SW_RD)
        begin
            unique case (SW_ADDR)
                `GP_H_ADDR: nxt_st.sw_rdata = st_ff.addr;
                `GP_H_DATA: nxt_st.sw_rdata = st_ff.data;
                `GP_H_STAT: nxt_st.sw_rdata = {7'h00, busy};
                `GP_H_RDAT: nxt_st.sw_rdata = st_ff.rdat;
                default: nxt_st.sw_rdata = 8'h00;
            endcase
        end

        unique case (st_ff.state)
            GP_H_IDLE:
            begin
                nxt_st.l_addr = st_ff.l_addr;
            end
            GP_H_WR1:
            begin
                nxt_st.l_addr = st_ff.addr;
                nxt_st.l_wdata = st_ff.data;
                nxt_st.l_wr = 1'b1;
                if (st_ff.dbl)
                begin
                    nxt_st.state = GP_H_WR2;
                end
                else
                begin
                    nxt_st.state = st_ff.then_rd ? GP_H_RD : GP_H_IDLE;
                end
                if (st_ff.addr == `GP_ADDR_CTL)
                begin
                    nxt_st.shadow = st_ff.data;
                    // set-up is remembered; later data changes go single
                    nxt_st.done1 = st_ff.data[`GP_B_P1_SEL] && st_ff.data[`GP_B_P1_DIR]
                        && (st_ff.done1 || st_ff.dbl);
                    nxt_st.done2 = st_ff.data[`GP_B_P2_SEL] && st_ff.data[`GP_B_P2_DIR]
                        && (st_ff.done2 || st_ff.dbl);
                end
            end
            GP_H_WR2:
            begin
                nxt_st.l_wr = 1'b1;
                nxt_st.state = st_ff.then_rd ? GP_H_RD : GP_H_IDLE;
            end
            GP_H_RD:
            begin
                nxt_st.l_addr = st_ff.addr;
                nxt_st.l_rd = 1'b1;
                nxt_st.then_rd = 1'b0;
                nxt_st.state = GP_H_CAP;
            end
            GP_H_CAP:
            begin
                // device read data is valid now, one cycle after the strobe
                if (!st_ff.l_rd)
                begin
                    nxt_st.rdat = LINK.rdata;
                    nxt_st.state = GP_H_IDLE;
                end
            end
            default: nxt_st.state = GP_H_IDLE;
        endcase

        if (RST)
        begin
            nxt_st = '0;
            nxt_st.state = GP_H_IDLE;
        end
    end

    always_ff @(posedge CLOCK)
    begin
        st_ff <= nxt_st;
    end

    assign LINK.addr = st_ff.l_addr;
    assign LINK.wdata = st_ff.l_wdata;
    assign LINK.wr = st_ff.l_wr;
    assign LINK.rd = st_ff.l_rd;
    assign SW_RDATA = st_ff.sw_rdata;
endmodule
`default_nettype wire

// file: sim/gp_link_properties.sv
// assertions on the register link and the device pins
// assumes instantiation beside the link interface in the bench
`timescale 1ns/1ps
`default_nettype none
`include "gp_defines.svh"
module gp_link_properties
(
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire logic MULTI_PIN_ONE_O,
    input wire logic MULTI_PIN_ONE_OE_N,
    input wire logic MULTI_PIN_TWO_O,
    input wire logic MULTI_PIN_TWO_OE_N,
    input wire logic RF_SYNC_INPUT_ONE,
    input wire logic RF_SYNC_INPUT_TWO,
    input wire logic IRQ
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (RST);
    // last control value written; top bit never stored
    logic [6:0] shadow_ff;
    always_ff @(posedge CLOCK)
    begin
        if (RST)
            shadow_ff <= 7'h00;
        else if (wr && addr == `GP_ADDR_CTL)
            shadow_ff <= wdata[6:0];
    end
    sequence s_out1;
        wr && addr == `GP_ADDR_CTL && wdata[1:0] == 2'b11;
    endsequence
    sequence s_out2;
        wr && addr == `GP_ADDR_CTL && wdata[4:3] == 2'b11 && !wdata[6];
    endsequence
    sequence s_int;
        wr && addr == `GP_ADDR_CTL && wdata == 8'hF8;
    endsequence
    // data expected on the pin is the bit carried by the second write
    property p_arm1;
        s_out1 ##1 s_out1
            |=> !MULTI_PIN_ONE_OE_N && MULTI_PIN_ONE_O == $past(wdata[2]);
    endproperty
    property p_arm2;
        s_out2 ##1 s_out2
            |=> !MULTI_PIN_TWO_OE_N && MULTI_PIN_TWO_O == $past(wdata[5]);
    endproperty
    property p_single2;
        (s_out2 and (!MULTI_PIN_TWO_OE_N && shadow_ff[4:3] == 2'b11 && !shadow_ff[6]))
            |=> !MULTI_PIN_TWO_OE_N && MULTI_PIN_TWO_O == $past(wdata[5]);
    endproperty
    // input-mode bits hold captured levels, so the echo is not checked while either pin is a gpio input
    AST_CTL_ECHO: assert property (rd && addr == `GP_ADDR_CTL
        && !(shadow_ff[0] && !shadow_ff[1]) && !(shadow_ff[3] && !shadow_ff[4])
        |=> rdata == {1'b0, shadow_ff})
        else $error("control readback differs from last write");
    AST_TOP_BIT: assert property (rd |=> !rdata[7])
        else $error("top control bit read as one");
    AST_RDATA_IDLE: assert property (!rd |=> rdata == 8'h00)
        else $error("read data not zero outside a read");
    AST_STROBES: assert property (!(wr && rd))
        else $error("write and read strobes together");
    AST_P1_ARM: assert property (p_arm1)
        else $error("pin one not driven after double write");
    AST_P2_ARM: assert property (p_arm2)
        else $error("pin two not driven after double write");
    AST_P2_SINGLE: assert property (p_single2)
        else $error("pin two data not updated by single write");
    AST_P2_FIRST: assert property (!(wr && addr == `GP_ADDR_CTL && wdata[4:3] == 2'b11
        && !wdata[6]) ##1 (s_out2 and (MULTI_PIN_TWO_OE_N && !shadow_ff[6]))
        |=> MULTI_PIN_TWO_OE_N)
        else $error("pin two driven after a single first write");
    AST_INT_MODE: assert property (s_int ##1 s_int ##1 !wr ##1 $stable(IRQ)
        |-> MULTI_PIN_TWO_OE_N == !IRQ && MULTI_PIN_TWO_O == 1'b0)
        else $error("interrupt output does not follow IRQ");
    AST_SYNC1_OFF: assert property (shadow_ff[0] [*3] |-> !RF_SYNC_INPUT_ONE)
        else $error("pin one sync output active in gpio mode");
    AST_SYNC2_OFF: assert property (shadow_ff[3] [*3] |-> !RF_SYNC_INPUT_TWO)
        else $error("pin two sync output active in gpio mode");
endmodule
`default_nettype wire

// file: sim/tb_top.sv
// bench: host end and device end joined by the link interface
// assumes design, package and interface compiled before this file
`timescale 1ns/1ps
`default_nettype none
`include "gp_defines.svh"
module tb_top;
    logic CLOCK, RST, sw_wr, sw_rd, drv_one, drv_two, fault, pin_one, pin_two;
    logic one_o, one_oe_n, two_o, two_oe_n, sync_one, sync_two, irq;
    logic [7:0] sw_addr, sw_wdata, sw_rdata, v;
    int err_count, comparisons, cycles;
    // open pins take the bench level unless the device drives them
    assign pin_one = one_oe_n ? drv_one : one_o;
    assign pin_two = two_oe_n ? drv_two : two_o;
    gp_link_if gp_link_if_inst();
    gp_host gp_host_inst (.CLOCK(CLOCK), .RST(RST), .LINK(gp_link_if_inst.host),
        .SW_ADDR(sw_addr), .SW_WDATA(sw_wdata), .SW_WR(sw_wr), .SW_RD(sw_rd),
        .SW_RDATA(sw_rdata));
    gp_dev gp_dev_inst (.CLOCK(CLOCK), .RST(RST), .LINK(gp_link_if_inst.dev),
        .MULTI_PIN_ONE_I(pin_one), .MULTI_PIN_ONE_O(one_o), .MULTI_PIN_ONE_OE_N(one_oe_n),
        .MULTI_PIN_TWO_I(pin_two), .MULTI_PIN_TWO_O(two_o), .MULTI_PIN_TWO_OE_N(two_oe_n),
        .FAULT_EVENT(fault), .RF_SYNC_INPUT_ONE(sync_one), .RF_SYNC_INPUT_TWO(sync_two),
        .IRQ(irq));
    gp_link_properties gp_link_properties_inst (.CLOCK(CLOCK), .RST(RST),
        .addr(gp_link_if_inst.addr), .wdata(gp_link_if_inst.wdata), .wr(gp_link_if_inst.wr),
        .rd(gp_link_if_inst.rd), .rdata(gp_link_if_inst.rdata), .MULTI_PIN_ONE_O(one_o),
        .MULTI_PIN_ONE_OE_N(one_oe_n), .MULTI_PIN_TWO_O(two_o), .MULTI_PIN_TWO_OE_N(two_oe_n),
        .RF_SYNC_INPUT_ONE(sync_one), .RF_SYNC_INPUT_TWO(sync_two), .IRQ(irq));
    initial
    begin
        CLOCK = 1'b0;
        forever #2.5 CLOCK = ~CLOCK;
    end
    task automatic conclude;
        $display("Comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic sw_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge CLOCK);
        sw_addr <= a;
        sw_wdata <= d;
        sw_wr <= 1'b1;
        @(posedge CLOCK);
        sw_wr <= 1'b0;
    endtask
    task automatic sw_read(input logic [7:0] a, output logic [7:0] d);
        @(posedge CLOCK);
        sw_addr <= a;
        sw_rd <= 1'b1;
        @(posedge CLOCK);
        sw_rd <= 1'b0;
        @(negedge CLOCK);
        d = sw_rdata;
    endtask
    // one host command, then poll busy; the host picks single or double writes
    task automatic host_op(input logic [7:0] a, input logic [7:0] d, input logic [7:0] c);
        logic [7:0] s;
        sw_write(`GP_H_ADDR, a);
        sw_write(`GP_H_DATA, d);
        sw_write(`GP_H_CMD, c);
        s = 8'h01;
        for (int i = 0; i < 20 && s[0] !== 1'b0; i++)
            sw_read(`GP_H_STAT, s);
        check("host busy", {7'h00, s[0]}, 8'h00);
        repeat (3) @(posedge CLOCK);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host_op(a, d, 8'h01);
    endtask
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
        host_op(a, 8'h00, 8'h02);
        sw_read(`GP_H_RDAT, v);
        check(what, v, exp);
    endtask
    // expectation bits: irq, one_oe_n, one_o, two_oe_n, two_o
    // sampled mid-cycle, away from the edge that updates the pin flops
    task automatic pins(input logic [7:0] exp);
        @(negedge CLOCK);
        check("pins", {3'h0, irq, one_oe_n, one_o, two_oe_n, two_o}, exp);
        @(posedge CLOCK);
    endtask
    always @(posedge CLOCK)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_count++;
            conclude();
        end
    end
    initial
    begin
        RST = 1'b1;
        sw_addr = 8'h00;
        sw_wdata = 8'h00;
        sw_wr = 1'b0;
        sw_rd = 1'b0;
        drv_one = 1'b0;
        drv_two = 1'b0;
        fault = 1'b0;
        repeat (10) @(posedge CLOCK);
        RST <= 1'b0;
        pins(8'h0A);
        rd_chk("ctl reset", `GP_ADDR_CTL, 8'h00);
        rd_chk("status reset", `GP_ADDR_STS, 8'h00);
        rd_chk("mask reset", `GP_ADDR_MSK, 8'h00);
        wr(`GP_ADDR_CTL, 8'h07);
        pins(8'h06);
        wr(`GP_ADDR_CTL, 8'hB8);
        pins(8'h09);
        rd_chk("ctl top bit", `GP_ADDR_CTL, 8'h38);
        wr(`GP_ADDR_CTL, 8'h18);
        pins(8'h08);
        drv_one <= 1'b1;
        drv_two <= 1'b1;
        wr(`GP_ADDR_CTL, 8'h09);
        repeat (6) @(posedge CLOCK);
        wr(`GP_ADDR_CTL, 8'h09);
        rd_chk("ctl capture", `GP_ADDR_CTL, 8'h2D);
        wr(`GP_ADDR_STS, 8'h07);
        rd_chk("status cleared", `GP_ADDR_STS, 8'h00);
        drv_one <= 1'b0;
        drv_two <= 1'b0;
        repeat (8) @(posedge CLOCK);
        rd_chk("status events", `GP_ADDR_STS, 8'h03);
        // undriven pins still show the captured data bits on their outputs
        pins(8'h0F);
        rd_chk("ctl held", `GP_ADDR_CTL, 8'h2D);
        wr(`GP_ADDR_MSK, 8'h01);
        pins(8'h1F);
        rd_chk("mask", `GP_ADDR_MSK, 8'h01);
        wr(`GP_ADDR_STS, 8'h01);
        rd_chk("status w1c", `GP_ADDR_STS, 8'h02);
        pins(8'h0F);
        host_op(`GP_ADDR_CTL, 8'h00, 8'h04);
        sw_read(`GP_H_RDAT, v);
        check("ctl refresh", v, 8'h09);
        wr(`GP_ADDR_STS, 8'h02);
        wr(`GP_ADDR_MSK, 8'h04);
        wr(`GP_ADDR_CTL, 8'h00);
        drv_one <= 1'b1;
        repeat (6) @(posedge CLOCK);
        check("sync outs", {6'h00, sync_one, sync_two}, 8'h02);
        wr(`GP_ADDR_CTL, 8'hF8);
        rd_chk("ctl int mode", `GP_ADDR_CTL, 8'h78);
        pins(8'h0A);
        @(posedge CLOCK);
        fault <= 1'b1;
        @(posedge CLOCK);
        fault <= 1'b0;
        repeat (4) @(posedge CLOCK);
        pins(8'h18);
        wr(`GP_ADDR_STS, 8'h04);
        pins(8'h0A);
        wr(`GP_ADDR_CTL, 8'h38);
        pins(8'h09);
        wr(8'h40, 8'hFF);
        rd_chk("unmapped", 8'h40, 8'h00);
        conclude();
    end
endmodule
`default_nettype wire
